// ===== core/cfg_reg8.v
`timescale 1ns/100ps
`default_nettype none
// one 8-bit control register with write mask and reset value
module cfg_reg8 #(
   parameter [7:0] RESET_VAL = 8'h00,
   parameter [7:0] WMASK = 8'hFF
) (
   // clock and reset
   input wire clk_i,
   input wire sys_rst_i,
   input wire soft_rst_i,
   // write port
   input wire wr_en_i,
   input wire [7:0] wr_data_i,
   // stored value
   output reg [7:0] q_o
);
   always @(posedge clk_i) begin
      if (sys_rst_i || soft_rst_i) begin
         q_o <= RESET_VAL;
      end else if (wr_en_i) begin
         q_o <= (q_o & ~WMASK) | (wr_data_i & WMASK);
      end
   end
endmodule // cfg_reg8
`default_nettype wire

// ===== core/codec_cfg_regs.vh
`ifndef CODEC_CFG_REGS_VH
`define CODEC_CFG_REGS_VH
`define ADDR_ROUTING 8'h0A
`define ADDR_GAIN 8'h0B
`define ADDR_RATE 8'h0C
`define ADDR_ECHO 8'h0D
`define RST_ROUTING 8'h10
`define RST_GAIN 8'h01
`define RST_RATE 8'h00
`define RST_ECHO 8'h00
`define ECHO_WMASK 8'h9E
`define RATE_WMASK 8'h7F
`define MIC_MUTE 3'h7
`define MIC_LAST_DEFINED 3'h3
`define PRE_MUTE 2'h2
`define RATE_RSV_BIT 2
`define RATE_VALID_CODE 3'h5
// version value is arbitrary, chosen for this build only
`define VERSION_BIT 1'h0
`endif

// ===== core/codec_route_gain_config_regs.v
`timescale 1ns/100ps
`default_nettype none
`include "codec_cfg_regs.vh"
module codec_route_gain_config_regs (
   // clock and reset
   input wire clk_i,
   input wire sys_rst_i,
   input wire soft_rst_i,
   // control port
   input wire wr_en_i,
   input wire [7:0] addr_i,
   input wire [7:0] wr_data_i,
   output reg [7:0] rd_data_o,
   output wire hit_o,
   // routing
   output wire handset_in_sel_o,
   output wire headset_in_sel_o,
   output wire microphone_in_sel_o,
   output wire line_in_sel_o,
   output wire caller_id_in_sel_o,
   output wire handset_out_sel_o,
   output wire headset_out_sel_o,
   output wire speaker_out_sel_o,
   // preamps
   output wire [1:0] handset_gain_o,
   output wire handset_in_mute_o,
   output wire [1:0] headset_gain_o,
   output wire headset_in_mute_o,
   output wire [2:0] mic_gain_o,
   output wire mic_mute_o,
   output wire speaker_pd_o,
   // frame rate and bias
   output wire [2:0] frame_sync_rate_o,
   output wire [3:0] bias_voltage_code_o,
   // echo and flags
   output wire handset_out_pd_o,
   output wire [2:0] echo_gain_o,
   output wire echo_mute_o,
   output wire valid_flag_en_o,
   // transmit sample marking
   input wire [15:0] tx_sample_i,
   input wire tx_sample_valid_i,
   output reg [15:0] tx_sample_o
);
   wire [7:0] routing_r;
   wire [7:0] gain_r;
   wire [7:0] rate_r;
   wire [7:0] echo_r;
   wire sel_routing;
   wire sel_gain;
   wire sel_rate;
   wire sel_echo;

   assign sel_routing = (addr_i == `ADDR_ROUTING);
   assign sel_gain = (addr_i == `ADDR_GAIN);
   assign sel_rate = (addr_i == `ADDR_RATE);
   assign sel_echo = (addr_i == `ADDR_ECHO);
   assign hit_o = sel_routing | sel_gain | sel_rate | sel_echo;

   // soft reset returns all four banks to their reset values
   cfg_reg8 #(.RESET_VAL(`RST_ROUTING), .WMASK(8'hFF)) u_routing (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst_i),
      .wr_en_i(wr_en_i & sel_routing), .wr_data_i(wr_data_i), .q_o(routing_r));
   cfg_reg8 #(.RESET_VAL(`RST_GAIN), .WMASK(8'hFF)) u_gain (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst_i),
      .wr_en_i(wr_en_i & sel_gain), .wr_data_i(wr_data_i), .q_o(gain_r));
   // bit 7 has no function, kept at zero
   cfg_reg8 #(.RESET_VAL(`RST_RATE), .WMASK(`RATE_WMASK)) u_rate (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst_i),
      .wr_en_i(wr_en_i & sel_rate), .wr_data_i(wr_data_i), .q_o(rate_r));
   // bits 6,5 don't care and bit 0 read-only: not stored
   cfg_reg8 #(.RESET_VAL(`RST_ECHO), .WMASK(`ECHO_WMASK)) u_echo (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst_i),
      .wr_en_i(wr_en_i & sel_echo), .wr_data_i(wr_data_i), .q_o(echo_r));

   assign handset_in_sel_o = routing_r[7];
   assign headset_in_sel_o = routing_r[6];
   assign microphone_in_sel_o = routing_r[5];
   assign line_in_sel_o = routing_r[4];
   assign caller_id_in_sel_o = routing_r[3];
   assign handset_out_sel_o = routing_r[2];
   assign headset_out_sel_o = routing_r[1];
   assign speaker_out_sel_o = routing_r[0];

   assign handset_gain_o = gain_r[7:6];
   assign handset_in_mute_o = (gain_r[7:6] == `PRE_MUTE);
   assign headset_gain_o = gain_r[5:4];
   assign headset_in_mute_o = (gain_r[5:4] == `PRE_MUTE);
   assign mic_gain_o = gain_r[3:1];
   // undefined codes 100..110 treated as mute to be safe
   assign mic_mute_o = (gain_r[3:1] > `MIC_LAST_DEFINED);
   assign speaker_pd_o = gain_r[0];

   rate_code_guard u_rate_guard (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst_i),
      .code_i(rate_r[6:4]), .rate_o(frame_sync_rate_o));
   assign bias_voltage_code_o = rate_r[3:0];

   assign handset_out_pd_o = echo_r[7];
   assign echo_gain_o = echo_r[4:2];
   assign echo_mute_o = (echo_r[4:2] == `MIC_MUTE);
   assign valid_flag_en_o = ~echo_r[1];

   // read mux; unmapped addresses read zero
   always @* begin
      case (addr_i)
         `ADDR_ROUTING: rd_data_o = routing_r;
         `ADDR_GAIN: rd_data_o = gain_r;
         `ADDR_RATE: rd_data_o = rate_r;
         `ADDR_ECHO: rd_data_o = {echo_r[7:1], `VERSION_BIT};
         default: rd_data_o = 8'h00;
      endcase
   end

   // msb carries validity when flag enabled
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         tx_sample_o <= 16'h0000;
      end else if (valid_flag_en_o) begin
         tx_sample_o <= {tx_sample_valid_i, tx_sample_i[14:0]};
      end else begin
         tx_sample_o <= tx_sample_i;
      end
   end
endmodule // codec_route_gain_config_regs
`default_nettype wire

// ===== core/rate_code_guard.v
`timescale 1ns/100ps
`default_nettype none
`include "codec_cfg_regs.vh"
// holds last legal frame-rate code; reserved codes are dropped
module rate_code_guard (
   // clock and reset
   input wire clk_i,
   input wire sys_rst_i,
   input wire soft_rst_i,
   // register value
   input wire [2:0] code_i,
   // effective rate
   output reg [2:0] rate_o
);
   wire legal;
   // reserved codes 100,110,111 would confuse the clock dividers
   assign legal = ~code_i[`RATE_RSV_BIT] || (code_i == `RATE_VALID_CODE);
   always @(posedge clk_i) begin
      if (sys_rst_i || soft_rst_i) begin
         rate_o <= 3'h0;
      end else if (legal) begin
         rate_o <= code_i;
      end
   end
endmodule // rate_code_guard
`default_nettype wire

// ===== tb/codec_cfg_regs_props.sv
`timescale 1ns/100ps
`default_nettype none
module codec_cfg_regs_chk (
   // watched ports
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic soft_rst_i,
   input wire logic wr_en_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic [7:0] rd_data_o,
   input wire logic hit_o,
   input wire logic line_in_sel_o,
   input wire logic speaker_pd_o,
   input wire logic [2:0] mic_gain_o,
   input wire logic mic_mute_o,
   input wire logic [2:0] frame_sync_rate_o,
   input wire logic valid_flag_en_o,
   input wire logic [15:0] tx_sample_i,
   input wire logic tx_sample_valid_i,
   input wire logic [15:0] tx_sample_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   hit_decode_a: assert property (hit_o == (addr_i >= 8'h0a && addr_i <= 8'h0d))
      else $error("decode wrong");
   gain_write_a: assert property (wr_en_i && addr_i == 8'h0b && !soft_rst_i |=>
      {mic_gain_o, speaker_pd_o} == 4'($past(wr_data_i))) else $error("gain write lost");
   mic_mute_a: assert property (mic_mute_o == mic_gain_o[2])
      else $error("mic mute wrong");
   soft_reset_a: assert property (soft_rst_i |=> speaker_pd_o && line_in_sel_o)
      else $error("soft reset missed");
   rate_legal_a: assert property ($changed(frame_sync_rate_o) |->
      !frame_sync_rate_o[2] || frame_sync_rate_o == 3'h5) else $error("reserved rate used");
   rate_apply_a: assert property (wr_en_i && addr_i == 8'h0c && !soft_rst_i &&
      wr_data_i[6:4] == 3'h5 |-> ##2 frame_sync_rate_o == 3'h5) else $error("rate not applied");
   version_bit_a: assert property (addr_i == 8'h0d |-> rd_data_o[0] == 1'b0)
      else $error("version bit wrong");
   tx_flag_a: assert property (!$past(sys_rst_i) |-> tx_sample_o == ($past(valid_flag_en_o) ?
      {$past(tx_sample_valid_i), 15'($past(tx_sample_i))} : $past(tx_sample_i)))
      else $error("sample flag wrong");
endmodule // codec_cfg_regs_chk
bind codec_route_gain_config_regs codec_cfg_regs_chk codec_cfg_regs_chk_i (.*);
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   int error_cnt = 0, n_tests = 0, cyc = 0;
   logic clk_i = 0, sys_rst_i = 1, soft_rst_i = 0, wr_en_i = 0, tx_sample_valid_i = 1;
   logic [7:0] addr_i = 0, wr_data_i = 0, rd_data_o;
   logic [15:0] tx_sample_i = 16'h0123, tx_sample_o;
   logic hit_o, handset_in_sel_o, headset_in_sel_o, microphone_in_sel_o, line_in_sel_o;
   logic caller_id_in_sel_o, handset_out_sel_o, headset_out_sel_o, speaker_out_sel_o;
   logic handset_in_mute_o, headset_in_mute_o, mic_mute_o, speaker_pd_o;
   logic handset_out_pd_o, echo_mute_o, valid_flag_en_o;
   logic [1:0] handset_gain_o, headset_gain_o;
   logic [2:0] mic_gain_o, frame_sync_rate_o, echo_gain_o, prv = 3'h5;
   logic [3:0] bias_voltage_code_o;
   logic [2:0] rc[7] = '{3'h4, 3'h6, 3'h7, 3'h0, 3'h1, 3'h2, 3'h3};
   always #50 clk_i = ~clk_i;
   codec_route_gain_config_regs codec_route_gain_config_regs_i (.*);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_en_i <= 1'h1;
      addr_i <= a;
      wr_data_i <= d;
      @(posedge clk_i);
      wr_en_i <= 1'h0;
      @(negedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      addr_i <= a;
      @(negedge clk_i);
      chk(rd_data_o, e);
   endtask
   task automatic final_report;
      $display("tests %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // a hang ends the run as a failure
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         final_report;
      end
   end
   initial begin
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'h0;
      rd(8'h0a, 8'h10);
      rd(8'h0b, 8'h01);
      rd(8'h0c, 8'h00);
      rd(8'h0d, 8'h00);
      rd(8'h0e, 8'h00);
      chk(hit_o, 1'h0);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         wr(8'h0a, 8'h01 << i);
         chk({handset_in_sel_o, headset_in_sel_o, microphone_in_sel_o, line_in_sel_o,
            caller_id_in_sel_o, handset_out_sel_o, headset_out_sel_o, speaker_out_sel_o},
            8'h01 << i);
         wr(8'h0b, {i[1:0], ~i[1:0], i[2:0], i[0]});
         chk({handset_in_mute_o, headset_in_mute_o}, {i[1:0] == 2'h2, i[1:0] == 2'h1});
         chk({handset_gain_o, headset_gain_o}, {i[1:0], ~i[1:0]});
         chk({mic_gain_o, mic_mute_o, speaker_pd_o}, {i[2:0], i[2], i[0]});
      end
      $display("routing and gain test done");
      wr(8'h0c, 8'hd5);
      rd(8'h0c, 8'h55);
      chk({frame_sync_rate_o, bias_voltage_code_o}, 7'h55);
      // reserved codes first, so a wrongly applied one would show
      foreach (rc[k]) begin
         wr(8'h0c, {1'h0, rc[k], 4'h0});
         @(negedge clk_i);
         if (!rc[k][2]) prv = rc[k];
         chk(frame_sync_rate_o, prv);
      end
      $display("rate test done");
      wr(8'h0d, 8'hfe);
      rd(8'h0d, 8'h9e);
      chk({handset_out_pd_o, echo_gain_o, echo_mute_o, valid_flag_en_o}, 6'h3e);
      chk(tx_sample_o, 16'h0123);
      wr(8'h0d, 8'h00);
      rd(8'h0d, 8'h00);
      chk(tx_sample_o, 16'h8123);
      @(posedge clk_i);
      tx_sample_i <= 16'h8123;
      tx_sample_valid_i <= 1'h0;
      repeat (2) @(negedge clk_i);
      chk(tx_sample_o, 16'h0123);
      $display("echo and flag test done");
      @(posedge clk_i);
      soft_rst_i <= 1'h1;
      @(posedge clk_i);
      soft_rst_i <= 1'h0;
      rd(8'h0a, 8'h10);
      rd(8'h0b, 8'h01);
      rd(8'h0c, 8'h00);
      rd(8'h0d, 8'h00);
      chk(frame_sync_rate_o, 3'h0);
      $display("soft reset test done");
      final_report;
   end
endmodule // tb
`default_nettype wire
